// File: rtl/gdio_pkg.sv
// Shared constants for the general digital I/O port block.
package gdio_pkg;
    localparam int NUM_PORTS = 2;
    localparam int PINS_PER_PORT = 8;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IDX_W = 8;
    // Register indices; the byte address is four times the index.
    localparam logic [IDX_W-1:0] IDX_PIN_INPUT_BASE = 8'h00;
    localparam logic [IDX_W-1:0] IDX_DIRECTION_BASE = 8'h01;
    localparam logic [IDX_W-1:0] IDX_OUTPUT_VALUE_BASE = 8'h02;
    localparam logic [IDX_W-1:0] IDX_PORT_STRIDE = 8'h03;
    localparam logic [IDX_W-1:0] IDX_MCU_CONTROL = 8'h35;
    localparam logic [IDX_W-1:0] IDX_PORT_CONTROL = 8'h12;
    // Field positions.
    localparam int MCU_PUD_BIT = 4;
    localparam int PCR_BBM_LSB = 4;
    localparam int PCR_PUD_LSB = 0;
    // Reset values.
    localparam logic [7:0] RST_PORT_REG = 8'h00;
    localparam logic [7:0] RST_CONTROL_REG = 8'h00;
endpackage : gdio_pkg

// File: rtl/gdio_sync.sv
// Pad input synchronizer: a falling-edge holding stage and a rising-edge stage.
`timescale 1ns/1ps
module gdio_sync #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] hold_reg;
    logic [W-1:0] q_reg;

    // The falling-edge stage samples what a latch transparent while the
    // clock is high would hold while it is low, without a latch race.
    always_ff @(negedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_reg <= '0;
        end else begin
            hold_reg <= d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_reg <= '0;
        end else begin
            q_reg <= hold_reg;
        end
    end

    assign q = q_reg;
endmodule : gdio_sync

// File: rtl/gdio_pin_ctl.sv
// Pad drive, pull-up and break-before-make control for the pins of one port.
`timescale 1ns/1ps
module gdio_pin_ctl #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Port settings
    input wire logic [W-1:0] direction_bits,
    input wire logic [W-1:0] output_value_bits,
    input wire logic bbm_enable,
    input wire logic pullup_disable,
    // Pad controls
    output logic [W-1:0] pad_oe,
    output logic [W-1:0] pad_pullup_en
);
    logic [W-1:0] dir_prev_reg;
    logic [W-1:0] dir_prev_next;
    logic [W-1:0] newly_out;

    always_comb begin
        dir_prev_next = direction_bits;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_prev_reg <= '0;
        end else begin
            dir_prev_reg <= dir_prev_next;
        end
    end

    // Only input-to-output moves are delayed; releases pass at once.
    assign newly_out = direction_bits & ~dir_prev_reg;
    // The reset term needs no clock, so pads float even with pclk stopped.
    assign pad_oe = direction_bits & ~({W{bbm_enable}} & newly_out)
        & {W{presetn}};
    assign pad_pullup_en = ~direction_bits & output_value_bits
        & {W{~pullup_disable}} & {W{presetn}};
endmodule : gdio_pin_ctl

// File: rtl/gdio_port_top.sv
// General digital I/O ports with an APB register slave.
//
// Operation
// - Direction bit one makes the pin an output, zero an input.
// - Input pin with output bit one gets pull-up; clear or output removes it.
// - Reset floats every pin, even with no clock running.
// - Output pin drives the pad to the output bit value.
// - Writing one to an input register bit inverts that output bit.
// - Break-before-make floats a newly made output for one cycle.
// - Break-before-make is enabled per port for all its pins.
// - Output-to-input change acts at once, with no floating cycle.
// - Pull-up only for input, output bit one, neither disable set.
// - Pad level readable for every pin through latch and flip-flop stages.
// - External change shows after half to one and a half clock periods.
// - Written value reads back one period later; software waits one idle.
// - Deep sleep clamp forces the digital input path to ground.
// - Clamp is overridden for pins whose external interrupt is enabled.
// - High pad on clamped disabled interrupt pin yields an edge on wake.
// - Software pull-ups are off while reset is active.
// - Port pull-up disable is ORed with the global pull-up disable.
// - Port control holds break-before-make at 5:4, pull-up disable 1:0.
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
module gdio_port_top
    import gdio_pkg::*;
#(
    parameter int NPORT = NUM_PORTS,
    parameter int NPIN = PINS_PER_PORT
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pads, port 0 in the low byte
    input wire logic [NPORT*NPIN-1:0] pad_in,
    output logic [NPORT*NPIN-1:0] pad_out,
    output logic [NPORT*NPIN-1:0] pad_oe,
    output logic [NPORT*NPIN-1:0] pad_pullup_en,
    // Sleep controller and interrupt controller
    input wire logic input_clamp,
    input wire logic [NPORT*NPIN-1:0] ext_int_enable,
    output logic [NPORT*NPIN-1:0] pin_level
);
    localparam int NP = NPORT * NPIN;

    logic [NPORT-1:0][NPIN-1:0] direction_reg;
    logic [NPORT-1:0][NPIN-1:0] direction_next;
    logic [NPORT-1:0][NPIN-1:0] output_value_reg;
    logic [NPORT-1:0][NPIN-1:0] output_value_next;
    logic [7:0] mcu_control_reg;
    logic [7:0] mcu_control_next;
    logic [7:0] port_control_reg;
    logic [7:0] port_control_next;
    logic [DATA_W-1:0] prdata_reg;
    logic [DATA_W-1:0] prdata_next;

    logic [IDX_W-1:0] idx;
    logic setup;
    logic wr_en;
    logic mapped;
    logic [NPORT-1:0] hit_pin;
    logic [NPORT-1:0] hit_dir;
    logic [NPORT-1:0] hit_out;
    logic hit_mcu;
    logic hit_pcr;
    logic [NP-1:0] clamped_in;
    logic [NPORT-1:0][NPIN-1:0] pin_input_bits;
    logic global_pullup_disable;
    logic [NPORT-1:0] portwise_pullup_disable;
    logic [NPORT-1:0] break_before_make_enable;

    // Address decode.
    assign idx = paddr[IDX_W+1:2];
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pwrite & pstrb[0];

    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            hit_pin[p] = idx == IDX_PIN_INPUT_BASE
                + IDX_W'(p) * IDX_PORT_STRIDE;
            hit_dir[p] = idx == IDX_DIRECTION_BASE
                + IDX_W'(p) * IDX_PORT_STRIDE;
            hit_out[p] = idx == IDX_OUTPUT_VALUE_BASE
                + IDX_W'(p) * IDX_PORT_STRIDE;
        end
        hit_mcu = idx == IDX_MCU_CONTROL;
        hit_pcr = idx == IDX_PORT_CONTROL;
        mapped = ((|hit_pin) | (|hit_dir) | (|hit_out) | hit_mcu | hit_pcr)
            & (paddr[1:0] == 2'b00);
    end

    // Zero wait states; unmapped or misaligned accesses answer with an error.
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // Control fields.
    assign global_pullup_disable = mcu_control_reg[MCU_PUD_BIT];
    assign portwise_pullup_disable =
        port_control_reg[PCR_PUD_LSB +: NPORT];
    assign break_before_make_enable =
        port_control_reg[PCR_BBM_LSB +: NPORT];

    // Register next values.
    always_comb begin
        direction_next = direction_reg;
        output_value_next = output_value_reg;
        mcu_control_next = mcu_control_reg;
        port_control_next = port_control_reg;
        if (wr_en && !pslverr) begin
            for (int p = 0; p < NPORT; p++) begin
                if (hit_dir[p]) begin
                    direction_next[p] = pwdata[NPIN-1:0];
                end
                if (hit_out[p]) begin
                    output_value_next[p] = pwdata[NPIN-1:0];
                end
                if (hit_pin[p]) begin
                    // Toggle regardless of direction setting.
                    output_value_next[p] = output_value_reg[p]
                        ^ pwdata[NPIN-1:0];
                end
            end
            if (hit_mcu) begin
                mcu_control_next = RST_CONTROL_REG;
                mcu_control_next[MCU_PUD_BIT] = pwdata[MCU_PUD_BIT];
            end
            if (hit_pcr) begin
                port_control_next = RST_CONTROL_REG;
                port_control_next[PCR_BBM_LSB +: NPORT] =
                    pwdata[PCR_BBM_LSB +: NPORT];
                port_control_next[PCR_PUD_LSB +: NPORT] =
                    pwdata[PCR_PUD_LSB +: NPORT];
            end
        end
    end

    // Read data is captured in the setup phase so it stands in the access
    // phase straight from a flip-flop.
    always_comb begin
        prdata_next = prdata_reg;
        if (setup && !pwrite) begin
            prdata_next = '0;
            for (int p = 0; p < NPORT; p++) begin
                if (hit_pin[p]) begin
                    prdata_next[NPIN-1:0] = pin_input_bits[p];
                end
                if (hit_dir[p]) begin
                    prdata_next[NPIN-1:0] = direction_reg[p];
                end
                if (hit_out[p]) begin
                    prdata_next[NPIN-1:0] = output_value_reg[p];
                end
            end
            if (hit_mcu) begin
                prdata_next[7:0] = mcu_control_reg;
            end
            if (hit_pcr) begin
                prdata_next[7:0] = port_control_reg;
            end
            // A refused read must not leak the register that the index hits.
            if (!mapped) begin
                prdata_next = '0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            direction_reg <= {NPORT{RST_PORT_REG}};
            output_value_reg <= {NPORT{RST_PORT_REG}};
            mcu_control_reg <= RST_CONTROL_REG;
            port_control_reg <= RST_CONTROL_REG;
            prdata_reg <= '0;
        end else begin
            direction_reg <= direction_next;
            output_value_reg <= output_value_next;
            mcu_control_reg <= mcu_control_next;
            port_control_reg <= port_control_next;
            prdata_reg <= prdata_next;
        end
    end

    assign prdata = prdata_reg;

    // Pad drive value comes straight from the output bits.
    assign pad_out = output_value_reg;

    // Per-port pad control.
    for (genvar p = 0; p < NPORT; p++) begin : g_port
        gdio_pin_ctl #(
            .W(NPIN)
        ) u_pin_ctl (
            .pclk(pclk),
            .presetn(presetn),
            .direction_bits(direction_reg[p]),
            .output_value_bits(output_value_reg[p]),
            .bbm_enable(break_before_make_enable[p]),
            .pullup_disable(global_pullup_disable
                | portwise_pullup_disable[p]),
            .pad_oe(pad_oe[p*NPIN +: NPIN]),
            .pad_pullup_en(pad_pullup_en[p*NPIN +: NPIN])
        );
    end

    // The clamp grounds the input ahead of the synchronizer, so a high pad
    // on a clamped pin shows as a rising edge when the clamp releases.
    assign clamped_in = pad_in
        & ~({NP{input_clamp}} & ~ext_int_enable);

    // Pad changes arrive half to one and a half periods later; a value
    // written at one edge is back at the next edge.
    gdio_sync #(
        .W(NP)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(clamped_in),
        .q(pin_input_bits)
    );

    assign pin_level = pin_input_bits;
endmodule : gdio_port_top

// File: dv/gdio_board_model.sv
// Board model: resolves each pad from device drive, pull-up and a driver.
`timescale 1ns/1ps
module gdio_board_model (
    // Clock
    input wire logic pclk,
    // Device side
    input wire logic [15:0] pad_out,
    input wire logic [15:0] pad_oe,
    input wire logic [15:0] pad_pullup_en,
    // External driver
    input wire logic [15:0] ext_en,
    input wire logic [15:0] ext_val,
    output logic [15:0] pad
);
    logic [15:0] flt = 16'h5555;
    // A floating pad wanders, so no check can lean on a stale level.
    always @(posedge pclk) flt <= ~flt;
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (pad_oe[i]) pad[i] = pad_out[i];
            else if (ext_en[i]) pad[i] = ext_val[i];
            else if (pad_pullup_en[i]) pad[i] = 1'b1;
            else pad[i] = flt[i];
        end
    end
endmodule : gdio_board_model

// File: dv/gdio_port_props.sv
// Checker for the general digital I/O port top level.
`timescale 1ns/1ps
module gdio_port_props #(
    parameter int NPORT = 2,
    parameter int NPIN = 8,
    localparam int W = NPORT * NPIN
) (
    // Clock, reset and bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    // Pads and sleep
    input wire logic [W-1:0] pad_in,
    input wire logic [W-1:0] pad_out,
    input wire logic [W-1:0] pad_oe,
    input wire logic [W-1:0] pad_pullup_en,
    input wire logic input_clamp,
    input wire logic [W-1:0] ext_int_enable,
    input wire logic [W-1:0] pin_level
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr;
    logic [W-1:0] din;
    assign wr = psel && penable && pwrite && pstrb[0];
    assign din = pad_in & ~({W{input_clamp}} & ~ext_int_enable);
    a_reset_float:
        assert property (disable iff (1'b0) !presetn
            |-> pad_oe == '0 && pad_pullup_en == '0) else $error("reset");
    a_pullup_gate:
        assert property ((pad_pullup_en & (pad_oe | ~pad_out)) == '0)
        else $error("pull-up");
    a_out_write:
        assert property (wr && paddr == 12'h008
            |=> pad_out[7:0] == $past(pwdata[7:0])) else $error("write");
    a_toggle_out:
        assert property (wr && paddr == 12'h000 |=> pad_out[7:0] ==
            ($past(pad_out[7:0]) ^ $past(pwdata[7:0]))) else $error("toggle");
    a_out_to_in:
        assert property (wr && paddr == 12'h004
            |=> (pad_oe[7:0] & ~$past(pwdata[7:0])) == 8'h00) else $error("oe");
    a_sync_delay:
        assert property ($past(presetn) |-> pin_level == $past(din))
        else $error("sync");
    a_clamp_path:
        assert property ($past(presetn) && $past(input_clamp)
            |-> (pin_level & ~$past(ext_int_enable)) == '0) else $error("clamp");
    a_out_hold:
        assert property (!wr |=> $stable(pad_out)) else $error("hold");
    c_pullup: cover property (pad_pullup_en != '0);
    c_clamp: cover property (input_clamp && ext_int_enable != '0);
    c_toggle: cover property (wr && paddr == 12'h000);
endmodule : gdio_port_props
bind gdio_port_top gdio_port_props #(.NPORT(NPORT), .NPIN(NPIN))
    gdio_port_props_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pad_in, .pad_out, .pad_oe, .pad_pullup_en,
    .input_clamp, .ext_int_enable, .pin_level);

// File: dv/test_general_digital_io_port.sv
// Self-checking bench for the general digital I/O port.
`timescale 1ns/1ps
module test_general_digital_io_port;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic input_clamp = 0, pready, pslverr, e, pg = 0, run = 1;
    logic [11:0] paddr = '0, b, ra [4] = '{12'h004, 12'h010, 12'h0d4, 12'h048};
    logic [31:0] pwdata = '0, prdata, r, seed = 32'h38c4_f4a5;
    logic [3:0] pstrb = 4'hf;
    logic [15:0] pad_in, pad_out, pad_oe, pad_pullup_en, pin_level, o, m, lv;
    logic [15:0] ext_int_enable = '0, ext_en = '0, ext_val = '0;
    logic [7:0] dr [2] = '{0, 0}, ov [2] = '{0, 0}, t;
    logic [1:0] pp = '0;
    int n_errors = 0, num_checks = 0, p;
    always #20 if (run) pclk = ~pclk;
    gdio_port_top gdio_port_top_inst (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .pad_in,
        .pad_out, .pad_oe, .pad_pullup_en, .input_clamp, .ext_int_enable,
        .pin_level);
    gdio_board_model gdio_board_model_inst (.pclk, .pad_out, .pad_oe,
        .pad_pullup_en, .ext_en, .ext_val, .pad(pad_in));
    function automatic logic [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction : rnd
    function automatic logic [15:0] e_pu();
        return ~{dr[1], dr[0]} & {ov[1], ov[0]}
            & ~{{8{pg | pp[1]}}, {8{pg | pp[0]}}};
    endfunction : e_pu
    function automatic logic [15:0] e_lv(input logic [15:0] d);
        return d & {ov[1], ov[0]} | ~d & ~(ext_en & ~ext_val);
    endfunction : e_lv
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        num_checks++;
        if (g !== x) begin
            n_errors++;
            $display("BAD t=%0t got %h exp %h", $time, g, x);
        end
    endtask : chk
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : complete_run
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        // Let the write edge settle before anyone looks at the pads.
        #1;
        if (n >= 20) begin
            n_errors++;
            complete_run();
        end
    endtask : apb
    task automatic cmp_pads();
        chk(32'(pad_out), 32'({ov[1], ov[0]}));
        chk(32'(pad_oe), 32'({dr[1], dr[0]}));
        chk(32'(pad_pullup_en), 32'(e_pu()));
    endtask : cmp_pads
    initial begin
        repeat (2) @(posedge pclk);
        #1;
        cmp_pads();
        @(posedge pclk);
        presetn <= 1;
        foreach (ra[i]) begin
            apb(0, ra[i], 0);
            chk(r, 0);
        end
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            p = i % 2;
            b = p ? 12'h00c : 12'h000;
            @(posedge pclk);
            ext_en <= {rnd(), rnd()};
            ext_val <= {rnd(), rnd()};
            // Output bit first, then direction, so no forbidden jump occurs.
            ov[p] = rnd();
            apb(1, b + 12'h008, {24'h0, ov[p]});
            cmp_pads();
            dr[p] = rnd();
            apb(1, b + 12'h004, {24'h0, dr[p]});
            t = rnd();
            pg = t[4];
            apb(1, 12'h0d4, {24'h0, t});
            pp = t[1:0];
            apb(1, 12'h048, {24'h0, t & 8'h03});
            t = rnd();
            ov[p] ^= t;
            apb(1, b, {24'h0, t});
            cmp_pads();
            @(posedge pclk);
            #1;
            o = {dr[1], dr[0]};
            m = o | ext_en | e_pu();
            lv = e_lv(o) & m;
            chk(32'(pin_level & m), 32'(lv));
            apb(0, b + 12'h004, 0);
            chk({r[30:0], e}, 32'({dr[p], 1'b0}));
            apb(0, b, 0);
            chk(r & {24'hff_ffff, m[8*p +: 8]},
                {24'h0, lv[8*p +: 8]});
            apb(0, b + 12'h008, 0);
            chk(r, {24'h0, ov[p]});
        end
        apb(0, 12'h0fc, 0);
        chk({r[30:0], e}, 1);
        apb(1, 12'h009, 32'h0000_00ff);
        cmp_pads();
        apb(0, 12'h006, 0);
        chk({r[30:0], e}, 1);
        // A write with the low byte strobe off must leave the pads alone.
        @(posedge pclk);
        pstrb <= 4'h0;
        apb(1, 12'h008, {24'h0, ~ov[0]});
        cmp_pads();
        @(posedge pclk);
        pstrb <= 4'hf;
        apb(0, 12'h0d4, 0);
        chk(r, 32'({pg, 4'h0}));
        $display("test random done");
        apb(1, 12'h004, 0);
        apb(1, 12'h010, 0);
        apb(1, 12'h048, 32'h0000_0010);
        apb(1, 12'h004, 32'h0000_00ff);
        chk(32'(pad_oe), 0);
        @(posedge pclk);
        #1;
        chk(32'(pad_oe), 32'h0000_00ff);
        apb(1, 12'h010, 32'h0000_00ff);
        chk(32'(pad_oe), 32'h0000_ffff);
        apb(1, 12'h004, 0);
        chk(32'(pad_oe), 32'h0000_ff00);
        apb(1, 12'h048, 32'hffff_ffff);
        apb(0, 12'h048, 0);
        chk(r, 32'h0000_0033);
        $display("test bbm done");
        apb(1, 12'h048, 0);
        apb(1, 12'h0d4, 0);
        apb(1, 12'h008, 32'h0000_00ff);
        chk(32'(pad_pullup_en), 32'h0000_00ff);
        // Stop the clock first: the pads must float with no edge at all.
        @(posedge pclk);
        run = 0;
        presetn <= 0;
        #50;
        chk(32'(pad_oe | pad_pullup_en), 0);
        run = 1;
        repeat (3) @(posedge pclk);
        presetn <= 1;
        $display("test async reset done");
        ext_en <= 16'hffff;
        ext_val <= 16'hffff;
        input_clamp <= 1;
        ext_int_enable <= {rnd(), rnd()};
        repeat (2) @(posedge pclk);
        #1;
        chk(32'(pin_level), 32'(ext_int_enable));
        @(posedge pclk);
        input_clamp <= 0;
        repeat (2) @(posedge pclk);
        #1;
        chk(32'(pin_level), 32'h0000_ffff);
        $display("test clamp done");
        complete_run();
    end
endmodule : test_general_digital_io_port
